// *** design/ds3_remote_loopback_request.sv ***
// Purpose: Remote loopback request send and detect for a DS3/DS1 multiplexer
// Assumes: Register port, framer flags and observations all on clk
// Notes:   Flags never alter the data path; software acts on them
//
// Summary of operation
// - With method select 0 the connect field is ignored and the send bit starts or stops inversion.
// - A new single channel inversion request replaces the one being sent.
// - The all-channels command sends inversion requests on every channel at once.
// - Request flags sit in 08H-0BH with all at 08H bit 7, DS3 at 09H bit 7, channels interleaved.
// - In M13 mode a channel flag sets after five successive selected inversions.
// - The inversion kinds that count are chosen by the select bits at 20H.
// - A bit-pattern flag clears after five successive normal occurrences.
// - In C-bit mode five activate words then five channel words set a flag.
// - In C-bit mode five deactivate words then a channel word clear a flag.
// - In C-bit mode inversion detection keeps running beside feac detection.
// - Any number of channel flags may be set together.
// - Inversion detection runs only with DS2 and DS3 frame sync.
// - Feac detection runs only with DS3 sync and no DS3 AIS or idle.
// - All and DS3 flags never show in M13 mode.
`timescale 1ns/1ps
module ds3_remote_loopback_request #(
  parameter logic [3:0] FEAC_REPEAT = lbr_pkg::FEAC_REPEAT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  addr,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  output      logic [7:0]  rd_data,
  input  wire logic        cbit_mode,
  input  wire logic        ds2_sync,
  input  wire logic        ds3_sync,
  input  wire logic        ds3_ais,
  input  wire logic        ds3_idle,
  input  wire logic        obs_valid,
  input  wire logic [4:0]  obs_chan,
  input  wire logic        obs_cbit_inv,
  input  wire logic        obs_stuff_inv,
  input  wire logic        rx_feac_valid,
  input  wire logic [5:0]  rx_feac_word,
  output      logic [27:0] tx_inv_mask,
  output      logic        tx_inv_cbit,
  output      logic        tx_inv_stuff,
  output      logic        feac_clock_input_sel,
  output      logic        tx_feac_valid,
  output      logic [5:0]  tx_feac_word,
  input  wire logic        tx_feac_ready
);
  localparam int N = lbr_pkg::NUM_CH;

  feac_if fb ();

  logic [7:0]   tx_req_q;
  logic [7:0]   feac_ctl_q;
  logic [7:0]   inv_sel_q;
  logic [7:0]   rd_data_q;
  logic [N-1:0] tx_mask_q;
  logic [N-1:0] tx_mask_d;
  logic [N-1:0] inv_flag_q;
  logic [2:0]   inv_cnt_q [N];
  logic [N-1:0] feac_ch_q;
  logic         feac_all_q;
  logic         feac_ds3_q;
  logic [N-1:0] chan_flags;
  logic         rq_all;
  logic         rq_ds3;

  // Gathers the flags of every fourth channel, from offset r, for one status register
  function automatic logic [6:0] pick(input logic [N-1:0] f, input int r);
    logic [6:0] v;
    v = 7'h00;
    for (int b = 0; b < 7; b++) begin
      v[b] = f[4*b+r];
    end
    return v;
  endfunction

  // Register write decode
  logic       wr_tx;
  logic       wr_feac;
  logic       wr_inv;
  logic       w_send;
  logic       w_method;
  logic       w_conn;
  logic [4:0] w_tgt;
  logic       w_is_ch;
  assign wr_tx    = ce && wr_en && addr == lbr_pkg::ADDR_TX_REQ;
  assign wr_feac  = ce && wr_en && addr == lbr_pkg::ADDR_FEAC_CTL;
  assign wr_inv   = ce && wr_en && addr == lbr_pkg::ADDR_INV_SEL;
  assign w_send   = wr_data[lbr_pkg::TX_SEND_BIT];
  assign w_method = wr_data[lbr_pkg::TX_METHOD_BIT];
  assign w_conn   = wr_data[lbr_pkg::TX_CONN_BIT];
  assign w_tgt    = wr_data[lbr_pkg::TX_TGT_LSB +: lbr_pkg::TX_TGT_W];
  assign w_is_ch  = w_tgt != 5'h00 && w_tgt <= lbr_pkg::TGT_MAX_CH;

  // Inversion mask: one channel, all channels or none
  assign tx_mask_d = !w_send ? '0 :
                     (w_tgt == lbr_pkg::TGT_ALL) ? '1 :
                     w_is_ch ? N'(1) << (w_tgt - 5'h01) : '0;

  // Control registers and transmit mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_req_q   <= lbr_pkg::TX_REQ_RST;
      feac_ctl_q <= lbr_pkg::FEAC_CTL_RST;
      inv_sel_q  <= lbr_pkg::INV_SEL_RST;
      tx_mask_q  <= '0;
    end else begin
      if (wr_tx) begin
        tx_req_q <= wr_data;
      end
      if (wr_tx && !w_method) begin
        tx_mask_q <= tx_mask_d;
      end
      if (wr_feac) begin
        feac_ctl_q <= wr_data;
      end
      if (wr_inv) begin
        inv_sel_q <= wr_data;
      end
    end
  end

  assign tx_inv_mask          = tx_mask_q;
  assign tx_inv_cbit          = inv_sel_q[lbr_pkg::INV_TX_CBIT];
  assign tx_inv_stuff         = inv_sel_q[lbr_pkg::INV_TX_STUFF];
  assign feac_clock_input_sel = feac_ctl_q[lbr_pkg::FEAC_CLK_BIT];

  // Feac send path, started by a method select 1 write
  assign fb.tx_start    = wr_tx && w_method;
  assign fb.tx_activate = w_conn;
  assign fb.tx_tgt      = w_tgt;
  assign fb.tx_ready    = tx_feac_ready;
  assign tx_feac_valid  = fb.tx_valid;
  assign tx_feac_word   = fb.tx_word;

  feac_tx_sender #(.REPEAT(FEAC_REPEAT)) u_tx (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .bus   (fb)
  );

  // Inversion detection, qualified by frame sync in either mode
  logic       inv_ok;
  logic [4:0] obs_idx;
  logic       obs_hit;
  logic       obs_cond;
  logic       obs_differ;
  logic [2:0] obs_inc;
  assign inv_ok     = ds2_sync && ds3_sync;
  assign obs_idx    = obs_chan - 5'h01;
  assign obs_hit    = obs_valid && inv_ok && obs_chan != 5'h00 &&
                      obs_chan <= lbr_pkg::TGT_MAX_CH;
  assign obs_cond   = (inv_sel_q[lbr_pkg::INV_RX_CBIT] && obs_cbit_inv) ||
                      (inv_sel_q[lbr_pkg::INV_RX_STUFF] && obs_stuff_inv);
  assign obs_differ = obs_cond != inv_flag_q[obs_idx];
  assign obs_inc    = inv_cnt_q[obs_idx] + 3'h1;

  // Per-channel run counters toggle the flag after a full run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        inv_cnt_q[i] <= 3'h0;
      end
      inv_flag_q <= '0;
    end else if (ce && !inv_ok) begin
      for (int i = 0; i < N; i++) begin
        inv_cnt_q[i] <= 3'h0;
      end
    end else if (ce && obs_hit) begin
      if (!obs_differ) begin
        inv_cnt_q[obs_idx] <= 3'h0;
      end else if (obs_inc == lbr_pkg::RUN_LEN) begin
        inv_cnt_q[obs_idx]  <= 3'h0;
        inv_flag_q[obs_idx] <= ~inv_flag_q[obs_idx];
      end else begin
        inv_cnt_q[obs_idx] <= obs_inc;
      end
    end
  end

  // Feac receive path, enabled only with clean DS3 framing
  assign fb.rx_en    = cbit_mode && ds3_sync && !ds3_ais && !ds3_idle;
  assign fb.rx_valid = rx_feac_valid;
  assign fb.rx_word  = rx_feac_word;

  feac_rx_detector u_rx (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .bus   (fb)
  );

  // Feac flags, each channel independent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feac_ch_q  <= '0;
      feac_all_q <= 1'b0;
      feac_ds3_q <= 1'b0;
    end else if (ce && fb.ev_valid) begin
      if (fb.ev_tgt == lbr_pkg::TGT_ALL) begin
        feac_all_q <= fb.ev_set;
      end else if (fb.ev_tgt == lbr_pkg::TGT_DS3) begin
        feac_ds3_q <= fb.ev_set;
      end else begin
        feac_ch_q[fb.ev_tgt - 5'h01] <= fb.ev_set;
      end
    end
  end

  // Reported state merges both detectors
  assign chan_flags = inv_flag_q | feac_ch_q;
  assign rq_all     = feac_all_q && cbit_mode;
  assign rq_ds3     = feac_ds3_q && cbit_mode;

  // Read mux; status registers have no write path
  logic [7:0] rd_mux;
  assign rd_mux = (addr == lbr_pkg::ADDR_TX_REQ)   ? tx_req_q :
                  (addr == lbr_pkg::ADDR_RQ_A)     ? {rq_all, pick(chan_flags, 0)} :
                  (addr == lbr_pkg::ADDR_RQ_B)     ? {rq_ds3, pick(chan_flags, 1)} :
                  (addr == lbr_pkg::ADDR_RQ_C)     ? {1'b0, pick(chan_flags, 2)} :
                  (addr == lbr_pkg::ADDR_RQ_D)     ? {1'b0, pick(chan_flags, 3)} :
                  (addr == lbr_pkg::ADDR_FEAC_CTL) ? feac_ctl_q :
                  (addr == lbr_pkg::ADDR_INV_SEL)  ? inv_sel_q : 8'h00;

  // Read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (ce && rd_en) begin
      rd_data_q <= rd_mux;
    end
  end

  assign rd_data = rd_data_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_write;
    wr_tx && !w_method && !w_send;
  endsequence

  sequence s_all_write;
    wr_tx && !w_method && w_send && w_tgt == lbr_pkg::TGT_ALL;
  endsequence

  sequence s_chan_write;
    wr_tx && !w_method && w_send && w_is_ch;
  endsequence

  sequence s_feac_set_ch;
    ce && fb.ev_valid && fb.ev_set && fb.ev_tgt <= lbr_pkg::TGT_MAX_CH;
  endsequence

  sequence s_feac_clr_ch;
    ce && fb.ev_valid && !fb.ev_set && fb.ev_tgt <= lbr_pkg::TGT_MAX_CH;
  endsequence

  sequence s_m13_flag_read;
    ce && rd_en && !cbit_mode && (addr == lbr_pkg::ADDR_RQ_A || addr == lbr_pkg::ADDR_RQ_B);
  endsequence

  sequence s_reserved_read;
    ce && rd_en && (addr == lbr_pkg::ADDR_RQ_C || addr == lbr_pkg::ADDR_RQ_D);
  endsequence

  a_m13_no_all: assert property (s_m13_flag_read |=> !rd_data[7])
    else $error("all or ds3 flag shown in m13 mode");

  a_stop_clears_mask: assert property (s_stop_write |=> tx_inv_mask == '0)
    else $error("inversion request not stopped");

  a_all_chan_mask: assert property (s_all_write |=> &tx_inv_mask)
    else $error("all-channels request not on every channel");

  a_single_chan_mask: assert property ($onehot0(tx_inv_mask) || &tx_inv_mask)
    else $error("more than one single-channel request sent");

  a_chan_replaces: assert property (s_chan_write |=> $onehot(tx_inv_mask))
    else $error("single-channel request did not replace the old one");

  a_feac_keeps_mask: assert property (wr_tx && w_method |=> $stable(tx_inv_mask))
    else $error("feac request changed the inversion mask");

  a_reserved_zero: assert property (s_reserved_read |=> !rd_data[7])
    else $error("reserved status bit read as one");

  a_read_shows_ch1: assert property (ce && rd_en && addr == lbr_pkg::ADDR_RQ_A |=>
                                     rd_data[0] == $past(chan_flags[0]))
    else $error("channel 1 flag not at its status bit");

  a_inv_needs_sync: assert property ($changed(inv_flag_q) |-> $past(inv_ok))
    else $error("inversion flag changed without frame sync");

  a_no_sync_hold: assert property (ce && !inv_ok |=> $stable(inv_flag_q))
    else $error("inversion flag moved without frame sync");

  a_feac_gate_hold: assert property (ce && !fb.rx_en && !obs_hit |=> $stable(feac_ch_q)
                                     && $stable(feac_all_q) && $stable(feac_ds3_q))
    else $error("feac flag moved while feac detection disabled");

  a_run_sets_flag: assert property ($rose(inv_flag_q[0]) |->
                                    $past(inv_cnt_q[0]) == lbr_pkg::RUN_LEN - 3'h1)
    else $error("channel flag set before a full run");

  a_run_clears_flag: assert property ($fell(inv_flag_q[0]) |->
                                      $past(inv_cnt_q[0]) == lbr_pkg::RUN_LEN - 3'h1)
    else $error("channel flag cleared before a full run");

  a_feac_set_all: assert property (ce && fb.ev_valid && fb.ev_set &&
                                   fb.ev_tgt == lbr_pkg::TGT_ALL |=> feac_all_q)
    else $error("feac set event not recorded");

  a_feac_set_ds3: assert property (ce && fb.ev_valid && fb.ev_set &&
                                   fb.ev_tgt == lbr_pkg::TGT_DS3 |=> feac_ds3_q)
    else $error("feac ds3 set event not recorded");

  a_feac_set_chan: assert property (s_feac_set_ch |=>
                                    feac_ch_q[$past(fb.ev_tgt) - 5'h01])
    else $error("feac channel set event not recorded");

  a_feac_clr_chan: assert property (s_feac_clr_ch |=>
                                    !feac_ch_q[$past(fb.ev_tgt) - 5'h01])
    else $error("feac clear event not recorded");

  a_read_keeps: assert property (ce && rd_en && !obs_valid && !fb.ev_valid |=>
                                 $stable(chan_flags))
    else $error("read changed request flags");

endmodule // ds3_remote_loopback_request

// *** design/feac_if.sv ***
// Purpose: Carrier between the top block and its feac receive and send engines
// Assumes: All signals on clk
// Notes:   Event valid of the detector is a single-cycle pulse; ev_set and ev_tgt are levels
`timescale 1ns/1ps
interface feac_if;
  logic       rx_en;
  logic       rx_valid;
  logic [5:0] rx_word;
  logic       ev_valid;
  logic       ev_set;
  logic [4:0] ev_tgt;
  logic       tx_start;
  logic       tx_activate;
  logic [4:0] tx_tgt;
  logic       tx_busy;
  logic       tx_valid;
  logic [5:0] tx_word;
  logic       tx_ready;

  modport rx_det (input rx_en, rx_valid, rx_word, output ev_valid, ev_set, ev_tgt);
  modport tx_snd (input tx_start, tx_activate, tx_tgt, tx_ready,
                  output tx_busy, tx_valid, tx_word);
endinterface

// *** design/feac_rx_detector.sv ***
// Purpose: Recognises feac connect and disconnect sequences
// Assumes: rx_valid marks one received feac word
// Notes:   Any unexpected word restarts the search
`timescale 1ns/1ps
module feac_rx_detector (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  feac_if.rx_det   bus
);
  lbr_pkg::feac_rx_state_t st_q;
  logic                    deact_q;
  logic [2:0]              cnt_q;
  logic [4:0]              tgt_q;
  logic                    is_cmd;
  logic                    w_deact;
  logic [4:0]              w_tgt;
  logic [2:0]              cnt_inc;
  logic                    take;

  // Word decoding
  assign w_deact = bus.rx_word == lbr_pkg::FEAC_DEACT;
  assign is_cmd  = w_deact || bus.rx_word == lbr_pkg::FEAC_ACT;
  assign w_tgt   = lbr_pkg::word_target(bus.rx_word);
  assign cnt_inc = cnt_q + 3'h1;
  assign take    = ce && bus.rx_en && bus.rx_valid && !is_cmd && w_tgt != 5'h00;

  // Disconnect ends on one channel word, connect on a run of them
  assign bus.ev_valid = take && ((st_q == lbr_pkg::RX_ARMED && deact_q) ||
                        (st_q == lbr_pkg::RX_CHAN && !deact_q && w_tgt == tgt_q &&
                         cnt_inc == lbr_pkg::RUN_LEN));
  assign bus.ev_set   = !deact_q;
  assign bus.ev_tgt   = w_tgt;

  // Sequence tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= lbr_pkg::RX_IDLE;
      deact_q <= 1'b0;
      cnt_q   <= 3'h0;
      tgt_q   <= 5'h00;
    end else if (ce && !bus.rx_en) begin
      st_q  <= lbr_pkg::RX_IDLE;
      cnt_q <= 3'h0;
    end else if (ce && bus.rx_valid && is_cmd) begin
      if ((st_q == lbr_pkg::RX_CMD || st_q == lbr_pkg::RX_ARMED) && w_deact == deact_q) begin
        if (st_q == lbr_pkg::RX_CMD) begin
          cnt_q <= cnt_inc;
          if (cnt_inc == lbr_pkg::RUN_LEN) begin
            st_q <= lbr_pkg::RX_ARMED;
          end
        end
      end else begin
        st_q    <= lbr_pkg::RX_CMD;
        deact_q <= w_deact;
        cnt_q   <= 3'h1;
      end
    end else if (ce && bus.rx_valid) begin
      unique case (st_q)
        lbr_pkg::RX_ARMED, lbr_pkg::RX_CHAN: begin
          if (w_tgt == 5'h00 || deact_q || bus.ev_valid) begin
            st_q <= lbr_pkg::RX_IDLE;
          end else if (st_q == lbr_pkg::RX_CHAN && w_tgt == tgt_q) begin
            cnt_q <= cnt_inc;
          end else begin
            st_q  <= lbr_pkg::RX_CHAN;
            tgt_q <= w_tgt;
            cnt_q <= 3'h1;
          end
        end
        lbr_pkg::RX_IDLE, lbr_pkg::RX_CMD: begin
          st_q <= lbr_pkg::RX_IDLE;
        end
      endcase
    end
  end
endmodule // feac_rx_detector

// *** design/feac_tx_sender.sv ***
// Purpose: Sends a double-word feac request, each word repeated
// Assumes: tx_ready from the framer on clk
// Notes:   A start while busy is ignored
`timescale 1ns/1ps
module feac_tx_sender #(
  parameter logic [3:0] REPEAT = lbr_pkg::FEAC_REPEAT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  feac_if.tx_snd   bus
);
  lbr_pkg::feac_tx_state_t st_q;
  logic [5:0]              word_q;
  logic [5:0]              chan_q;
  logic [3:0]              cnt_q;
  logic                    beat;
  logic                    last;

  assign bus.tx_busy  = st_q != lbr_pkg::TX_IDLE;
  assign bus.tx_valid = bus.tx_busy;
  assign bus.tx_word  = word_q;
  assign beat         = ce && bus.tx_valid && bus.tx_ready;
  assign last         = cnt_q + 4'h1 == REPEAT;

  // Command word run, then channel word run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= lbr_pkg::TX_IDLE;
      word_q <= 6'h00;
      chan_q <= 6'h00;
      cnt_q  <= 4'h0;
    end else if (ce && st_q == lbr_pkg::TX_IDLE && bus.tx_start) begin
      st_q   <= lbr_pkg::TX_CMD;
      word_q <= bus.tx_activate ? lbr_pkg::FEAC_ACT : lbr_pkg::FEAC_DEACT;
      chan_q <= {1'b0, bus.tx_tgt};
      cnt_q  <= 4'h0;
    end else if (beat) begin
      cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
      if (last) begin
        st_q   <= (st_q == lbr_pkg::TX_CMD) ? lbr_pkg::TX_CHAN : lbr_pkg::TX_IDLE;
        word_q <= chan_q;
      end
    end
  end
endmodule // feac_tx_sender

// *** design/lbr_pkg.sv ***
// Purpose: Shared constants and types for the remote loopback request block
// Assumes: 8-bit register port, FEAC words are 6 bits wide
// Notes:   FEAC code points and control bit placements are block-local choices
package lbr_pkg;

  localparam int NUM_CH = 28;

  // Register addresses
  localparam logic [5:0] ADDR_TX_REQ   = 6'h07;
  localparam logic [5:0] ADDR_RQ_A     = 6'h08;
  localparam logic [5:0] ADDR_RQ_B     = 6'h09;
  localparam logic [5:0] ADDR_RQ_C     = 6'h0A;
  localparam logic [5:0] ADDR_RQ_D     = 6'h0B;
  localparam logic [5:0] ADDR_FEAC_CTL = 6'h19;
  localparam logic [5:0] ADDR_INV_SEL  = 6'h20;

  // Field positions of the transmit request register
  localparam int TX_SEND_BIT   = 7;
  localparam int TX_METHOD_BIT = 6;
  localparam int TX_CONN_BIT   = 5;
  localparam int TX_TGT_LSB    = 0;
  localparam int TX_TGT_W      = 5;

  // Field positions of the feac control and inversion select registers
  localparam int FEAC_CLK_BIT = 0;
  localparam int INV_RX_CBIT  = 0;
  localparam int INV_RX_STUFF = 1;
  localparam int INV_TX_CBIT  = 2;
  localparam int INV_TX_STUFF = 3;

  // Reset values
  localparam logic [7:0] TX_REQ_RST   = 8'h00;
  localparam logic [7:0] FEAC_CTL_RST = 8'h00;
  localparam logic [7:0] INV_SEL_RST  = 8'h00;

  // Targets carried in the low bits of a request
  localparam logic [4:0] TGT_ALL = 5'h1D;
  localparam logic [4:0] TGT_DS3 = 5'h1E;
  localparam logic [4:0] TGT_MAX_CH = 5'h1C;

  // Feac command words; values are arbitrary
  localparam logic [5:0] FEAC_ACT   = 6'h3A;
  localparam logic [5:0] FEAC_DEACT = 6'h3B;

  // Occurrence counts
  localparam logic [2:0] RUN_LEN     = 3'h5;
  localparam logic [3:0] FEAC_REPEAT = 4'hA;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_CMD   = 2'b01,
    RX_ARMED = 2'b11,
    RX_CHAN  = 2'b10
  } feac_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CMD  = 2'b01,
    TX_CHAN = 2'b11
  } feac_tx_state_t;

  // Target named by a feac channel word, zero when the word names none
  function automatic logic [4:0] word_target(input logic [5:0] w);
    word_target = (w != 6'h00 && w <= {1'b0, TGT_DS3}) ? w[4:0] : 5'h00;
  endfunction

endpackage

// *** dv/ds3_remote_loopback_request_tb.sv ***
// Purpose: Self-checking bench for remote loopback request send and detect
// Assumes: Inputs driven at the falling edge; FEAC repeat shortened to 2
// Notes:   Flag expectations kept in a small model of the four status registers
`timescale 1ns/1ps
module ds3_remote_loopback_request_tb;
  logic        clk, rst_n, ce, wr_en, rd_en, cbit_mode, ds2_sync, ds3_sync, ds3_ais, ds3_idle;
  logic [5:0]  addr, rx_feac_word, tx_feac_word;
  logic [7:0]  wr_data, rd_data, v;
  logic        obs_valid, obs_cbit_inv, obs_stuff_inv, rx_feac_valid, stall;
  logic [4:0]  obs_chan, ca, cb, cc, cd;
  logic [27:0] tx_inv_mask, fl;
  logic        tx_inv_cbit, tx_inv_stuff, feac_clock_input_sel, tx_feac_valid, tx_feac_ready;
  logic        f_all, f_ds3;
  integer      seed = 32'h3B9A;
  int          fails = 0, samples_checked = 0, cycles = 0;

  ds3_remote_loopback_request #(.FEAC_REPEAT(4'h2)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .cbit_mode(cbit_mode), .ds2_sync(ds2_sync), .ds3_sync(ds3_sync), .ds3_ais(ds3_ais),
    .ds3_idle(ds3_idle), .obs_valid(obs_valid), .obs_chan(obs_chan),
    .obs_cbit_inv(obs_cbit_inv), .obs_stuff_inv(obs_stuff_inv), .rx_feac_valid(rx_feac_valid),
    .rx_feac_word(rx_feac_word), .tx_inv_mask(tx_inv_mask), .tx_inv_cbit(tx_inv_cbit),
    .tx_inv_stuff(tx_inv_stuff), .feac_clock_input_sel(feac_clock_input_sel),
    .tx_feac_valid(tx_feac_valid), .tx_feac_word(tx_feac_word), .tx_feac_ready(tx_feac_ready));

  far_end_terminal far (.clk(clk), .stall(stall), .obs_valid(obs_valid), .obs_chan(obs_chan),
    .obs_cbit_inv(obs_cbit_inv), .obs_stuff_inv(obs_stuff_inv), .rx_feac_valid(rx_feac_valid),
    .rx_feac_word(rx_feac_word), .tx_feac_valid(tx_feac_valid), .tx_feac_word(tx_feac_word),
    .tx_feac_ready(tx_feac_ready));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wr_data, wr_en} = {a, d, 1'b1};
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    {addr, rd_en} = {a, 1'b1};
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
  endtask

  // Expected content of status register 08H plus r
  function automatic logic [7:0] exp_reg(input int r);
    logic [7:0] b;
    b[7] = (r == 0) ? (cbit_mode & f_all) : (r == 1) ? (cbit_mode & f_ds3) : 1'b0;
    for (int k = 0; k < 7; k++) b[k] = fl[4 * k + r];
    return b;
  endfunction

  task automatic chk_flags();
    for (int r = 0; r < 4; r++) begin
      rd(lbr_pkg::ADDR_RQ_A + 6'(r), v);
      check(v, exp_reg(r));
    end
  endtask

  task automatic obs_run(input logic [4:0] ch, input logic c, input logic s, input int n);
    repeat (n) far.send_obs(ch, c, s);
  endtask

  task automatic feac_seq(input logic [5:0] cmd, input logic [4:0] tgt, input int n);
    repeat (5) far.send_feac(cmd);
    repeat (n) far.send_feac({1'b0, tgt});
  endtask

  // Main sequence
  initial begin
    {rst_n, ce, wr_en, rd_en, addr, wr_data, stall} = {1'b0, 1'b1, 2'b00, 6'h00, 8'h00, 1'b0};
    {cbit_mode, ds2_sync, ds3_sync, ds3_ais, ds3_idle} = 5'b01100;
    {fl, f_all, f_ds3} = 30'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk_flags();
    rd(6'h3F, v);
    check(v, 8'h00);
    wr(lbr_pkg::ADDR_INV_SEL, 8'h05);
    check({tx_inv_stuff, tx_inv_cbit}, 2'b01);
    for (int i = 0; i < 6; i++) begin
      ca = 5'(($unsigned($random(seed)) % 28) + 1);
      wr(lbr_pkg::ADDR_TX_REQ, {2'b10, 1'($random(seed)), ca});
      check(tx_inv_mask, 28'h1 << (ca - 1));
    end
    wr(lbr_pkg::ADDR_TX_REQ, {3'b101, lbr_pkg::TGT_ALL});
    check(tx_inv_mask, 28'hFFFFFFF);
    wr(lbr_pkg::ADDR_TX_REQ, {3'b001, ca});
    check(tx_inv_mask, 28'h0);
    // Inversion detection in M13 mode, corners 1 and 28
    wr(lbr_pkg::ADDR_INV_SEL, 8'h01);
    obs_run(5'd1, 1'b1, 1'b0, 4);
    chk_flags();
    obs_run(5'd1, 1'b1, 1'b0, 1);
    fl[0] = 1'b1;
    chk_flags();
    chk_flags();
    obs_run(5'd28, 1'b0, 1'b1, 5);
    chk_flags();
    wr(lbr_pkg::ADDR_INV_SEL, 8'h02);
    obs_run(5'd28, 1'b0, 1'b1, 5);
    fl[27] = 1'b1;
    chk_flags();
    obs_run(5'd1, 1'b1, 1'b0, 4);
    obs_run(5'd1, 1'b0, 1'b1, 1);
    obs_run(5'd1, 1'b1, 1'b0, 4);
    chk_flags();
    obs_run(5'd1, 1'b0, 1'b0, 1);
    fl[0] = 1'b0;
    chk_flags();
    // Either sync lost blocks inversion detection
    cc = 5'(($unsigned($random(seed)) % 12) + 2);
    for (int i = 0; i < 2; i++) begin
      {ds2_sync, ds3_sync} = (i == 0) ? 2'b01 : 2'b10;
      obs_run(cc, 1'b0, 1'b1, 5);
      chk_flags();
    end
    {ds2_sync, ds3_sync} = 2'b11;
    // FEAC detection in C-bit mode
    cbit_mode = 1'b1;
    cd = cc + 5'd13;
    feac_seq(lbr_pkg::FEAC_ACT, cd, 4);
    chk_flags();
    far.send_feac({1'b0, cd});
    fl[cd - 1] = 1'b1;
    chk_flags();
    feac_seq(lbr_pkg::FEAC_ACT, lbr_pkg::TGT_ALL, 5);
    feac_seq(lbr_pkg::FEAC_ACT, lbr_pkg::TGT_DS3, 5);
    {f_all, f_ds3} = 2'b11;
    chk_flags();
    cbit_mode = 1'b0;
    chk_flags();
    cbit_mode = 1'b1;
    feac_seq(lbr_pkg::FEAC_DEACT, cd, 1);
    fl[cd - 1] = 1'b0;
    chk_flags();
    for (int i = 0; i < 3; i++) begin
      {ds3_ais, ds3_idle, ds3_sync} = (i == 0) ? 3'b101 : (i == 1) ? 3'b011 : 3'b000;
      feac_seq(lbr_pkg::FEAC_ACT, 5'd14, 5);
      chk_flags();
    end
    {ds3_ais, ds3_idle, ds3_sync} = 3'b001;
    obs_run(5'd27, 1'b0, 1'b1, 5);
    fl[26] = 1'b1;
    chk_flags();
    check(tx_inv_mask, 28'h0);
    // Mid-run reset drops every flag and control bit
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    {fl, f_all, f_ds3} = 30'h0;
    check({tx_feac_valid, feac_clock_input_sel, tx_inv_mask}, 30'h0);
    chk_flags();
    wr(lbr_pkg::ADDR_TX_REQ, {3'b100, ca});
    // FEAC request sent to the far end, with a slow acceptor
    wr(lbr_pkg::ADDR_FEAC_CTL, 8'h01);
    check(feac_clock_input_sel, 1'b1);
    stall = 1'b1;
    wr(lbr_pkg::ADDR_TX_REQ, {3'b111, cc});
    for (int t = 0; t < 400 && far.got_q.size() < 4; t++) @(negedge clk);
    check(far.got_q.size(), 4);
    for (int i = 0; i < 4; i++) begin
      check(far.got_q[i], (i < 2) ? lbr_pkg::FEAC_ACT : {1'b0, cc});
    end
    check(tx_inv_mask, 28'h1 << (ca - 1));
    end_sim();
  end
endmodule // ds3_remote_loopback_request_tb

// *** dv/far_end_terminal.sv ***
// Purpose: Distant DS3 terminal: sends DS2 occurrences and FEAC words, takes FEAC words
// Assumes: Drives its lines on the falling edge of clk
// Notes:   Idle data lines show the inverse of their last value
`timescale 1ns/1ps
module far_end_terminal (
  input  wire logic       clk,
  input  wire logic       stall,
  output      logic       obs_valid,
  output      logic [4:0] obs_chan,
  output      logic       obs_cbit_inv,
  output      logic       obs_stuff_inv,
  output      logic       rx_feac_valid,
  output      logic [5:0] rx_feac_word,
  input  wire logic       tx_feac_valid,
  input  wire logic [5:0] tx_feac_word,
  output      logic       tx_feac_ready
);
  integer     rdy_seed = 32'h3B9A;
  logic [5:0] got_q[$];
  // Quiet lines at time zero
  initial begin
    {obs_valid, obs_chan, obs_cbit_inv, obs_stuff_inv} = 8'h00;
    {rx_feac_valid, rx_feac_word} = 7'h00;
    tx_feac_ready = 1'b1;
  end
  // One DS2 C/stuff occurrence for a channel
  task automatic send_obs(input logic [4:0] ch, input logic c_inv, input logic s_inv);
    @(negedge clk);
    {obs_valid, obs_chan, obs_cbit_inv, obs_stuff_inv} = {1'b1, ch, c_inv, s_inv};
    @(negedge clk);
    {obs_valid, obs_chan, obs_cbit_inv, obs_stuff_inv} = {1'b0, ~ch, ~c_inv, ~s_inv};
  endtask
  // One received FEAC word
  task automatic send_feac(input logic [5:0] w);
    @(negedge clk);
    {rx_feac_valid, rx_feac_word} = {1'b1, w};
    @(negedge clk);
    {rx_feac_valid, rx_feac_word} = {1'b0, ~w};
  endtask
  // Accepts words promptly, or slowly at random while stalling
  always @(negedge clk) begin
    tx_feac_ready <= stall ? 1'($random(rdy_seed)) : 1'b1;
  end
  // Collects every accepted word
  always @(posedge clk) begin
    if (tx_feac_valid && tx_feac_ready) got_q.push_back(tx_feac_word);
  end
endmodule // far_end_terminal
